// *** hw/ext_bus_ack_termination.sv ***
// Acknowledge termination and time-out monitor for asynchronous external cycles
module ext_bus_ack_termination
    import ack_term_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cycle_start,
    input  wire cycle_cfg_t cycle_cfg,
    input  wire logic       transfer_ack_in,
    output logic            cycle_done,
    output logic            bus_error,
    output logic            cycle_busy
);
    // Time-out counter is 11 bits wide, so larger limits cannot be served
    if (TIMEOUT < 2 || TIMEOUT > 2047) begin : g_bad_timeout
        $error("TIMEOUT out of range");
    end

    localparam logic [10:0] TO_LAST = 11'(TIMEOUT - 1);
    localparam logic [2:0]  HB      = 3'(HOLDOFF_BASE);

    term_regs_t r_reg;
    term_regs_t r_next;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic edge_mode;
        logic ack_on;
        logic rise;
        edge_mode = 1'b0;
        ack_on    = 1'b0;
        rise      = 1'b0;
        r_next          = r_reg;
        r_next.done     = 1'b0;
        r_next.bus_error = 1'b0;
        r_next.ack_prev = transfer_ack_in;
        // Edge mode only honoured on the one select that supports it
        edge_mode = r_reg.cfg.edge_ack_select && r_reg.cfg.cs_sel == CS_EDGE_ONLY;
        // Level mode is refused on the select that shares the acknowledge pin
        ack_on = edge_mode || (!r_reg.cfg.edge_ack_select && r_reg.cfg.external_wait_enable
                 && r_reg.cfg.cs_sel != CS_SHARED_ACK);
        rise = transfer_ack_in && !r_reg.ack_prev;
        case (r_reg.state)
            ST_IDLE: begin
                if (cycle_start) begin
                    r_next.cfg         = cycle_cfg;
                    r_next.timeout_cnt = '0;
                    r_next.ws_cnt      = '0;
                    r_next.hold_cnt    = '0;
                    // Forcing the previous sample high here means a level left high from the last
                    // cycle is no edge: each transfer needs a fresh rising edge
                    r_next.ack_prev    = 1'b1;
                    r_next.state       = ST_HOLD;
                end
            end
            ST_HOLD: begin
                r_next.timeout_cnt = r_reg.timeout_cnt + 11'h001;
                r_next.hold_cnt    = r_reg.hold_cnt + 3'h1;
                if (edge_mode) begin
                    r_next.state = ST_WAIT;
                end else if (r_reg.hold_cnt + 3'h1 >= HB + 3'(r_reg.cfg.ack_holdoff_count)) begin
                    r_next.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                r_next.timeout_cnt = r_reg.timeout_cnt + 11'h001;
                if (edge_mode) begin
                    if (rise) begin
                        r_next.done  = 1'b1;
                        r_next.state = ST_IDLE;
                    end
                end else if (!ack_on || transfer_ack_in) begin
                    // Wait states advance while the acknowledge is high, or every clock when it is ignored
                    r_next.ws_cnt = r_reg.ws_cnt + 6'h01;
                    if (r_reg.ws_cnt >= r_reg.cfg.wait_state_count) begin
                        r_next.done  = 1'b1;
                        r_next.state = ST_IDLE;
                    end
                end
                // Pulse leaves with the return to idle, so busy is low while it stands
                if (ack_on && r_reg.timeout_cnt >= TO_LAST && !r_next.done) begin
                    r_next.bus_error = 1'b1;
                    r_next.state     = ST_IDLE;
                end
            end
            ST_DONE: begin
                r_next.state = ST_IDLE;
            end
            default: r_next.state = ST_IDLE;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.state <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign cycle_done = r_reg.done;
    assign bus_error  = r_reg.bus_error;
    assign cycle_busy = r_reg.state != ST_IDLE;
endmodule // ext_bus_ack_termination

// *** hw/ack_term_pkg.sv ***
// Constants and types for the external bus acknowledge termination block
// Summary of operation
// - With acknowledge termination on, a cycle unterminated after 1024 clocks raises bus error.
// - Two detection modes: rising edge, or level with programmable hold-off.
// - Edge mode ends the transfer on an acknowledge rising edge before time-out.
// - Edge detection works only for chip select five.
// - Every edge-mode transfer, back-to-back ones included, waits for a fresh edge.
// - Level mode ignores acknowledge for 2 to 5 clocks set by hold-off field.
// - Acknowledge high after hold-off: continue with programmed wait state count.
// - Acknowledge low after hold-off: stall until high, subject to time-out.
// - Acknowledge low anytime after hold-off during a level-mode transfer pauses it until high.
// - Level mode usable on every chip select except chip select four.
package ack_term_pkg;
    // ************************************************************
    // Numbers
    // ************************************************************
    localparam int          TIMEOUT_CYCLES  = 1024;
    localparam int          HOLDOFF_BASE    = 2;
    localparam int          HOLDOFF_MAX     = 5;
    localparam logic [2:0]  CS_EDGE_ONLY    = 3'h5;
    localparam logic [2:0]  CS_SHARED_ACK   = 3'h4;
    localparam logic [5:0]  WSC_EDGE_MODE   = 6'h3f;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_HOLD  = 2'b01,
        ST_WAIT  = 2'b10,
        ST_DONE  = 2'b11
    } term_state_t;

    typedef struct packed {
        logic [2:0] cs_sel;
        logic [5:0] wait_state_count;
        logic [1:0] ack_holdoff_count;
        logic       edge_ack_select;
        logic       external_wait_enable;
    } cycle_cfg_t;

    typedef struct packed {
        term_state_t state;
        cycle_cfg_t  cfg;
        logic [10:0] timeout_cnt;
        logic [5:0]  ws_cnt;
        logic [2:0]  hold_cnt;
        logic        ack_prev;
        logic        done;
        logic        bus_error;
    } term_regs_t;
endpackage

// *** bench/ext_bus_ack_termination_properties.sv ***
// Checker on the block ports
module ext_bus_ack_termination_properties import ack_term_pkg::*;
#(parameter int TIMEOUT = TIMEOUT_CYCLES) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cycle_start,
    input wire cycle_cfg_t cycle_cfg,
    input wire logic       transfer_ack_in,
    input wire logic       cycle_done,
    input wire logic       bus_error,
    input wire logic       cycle_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    cycle_cfg_t  cfg_reg;
    logic [11:0] cnt_reg;
    wire edg = cfg_reg.edge_ack_select && cfg_reg.cs_sel == CS_EDGE_ONLY;
    wire hld = edg && cycle_busy && transfer_ack_in;
    wire stl = !cfg_reg.edge_ack_select && cfg_reg.external_wait_enable
               && cfg_reg.cs_sel != CS_SHARED_ACK && cycle_busy && !transfer_ack_in;
    always_ff @(posedge clk)
        if (!rst_n) cnt_reg <= 12'h000;
        else if (cycle_start && !cycle_busy) {cnt_reg, cfg_reg} <= {12'h000, cycle_cfg};
        else if (cycle_busy) cnt_reg <= cnt_reg + 12'h001;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_EXCL: assert property (!(cycle_done && bus_error)) else $error("both");
    AST_DP: assert property (cycle_done |=> !cycle_done) else $error("long done");
    AST_EP: assert property (bus_error |=> !bus_error) else $error("long error");
    AST_TAKE: assert property (cycle_start && !cycle_busy |=> cycle_busy) else $error("idle");
    AST_END: assert property (cycle_done || bus_error |-> !cycle_busy) else $error("busy");
    AST_STALL: assert property (stl [*4] |=> !cycle_done) else $error("no stall");
    AST_EDGE: assert property (hld [*8] |=> !cycle_done) else $error("no edge");
    AST_TIME: assert property (bus_error |-> cnt_reg inside {[TIMEOUT-2:TIMEOUT+4]})
        else $error("error time");
    cover property (cycle_done && edg);
    cover property (cycle_done && !edg);
    cover property (bus_error);
endmodule // ext_bus_ack_termination_properties

// *** bench/ack_device_model.sv ***
// Far-side device driving the acknowledge
module ack_device_model (
    input wire logic       clk,
    input wire logic       cycle_busy,
    input wire logic [9:0] low_cycles,
    output logic           transfer_ack_in = 1'h1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] cnt_reg = 10'h000;
    // Idle high, so no stale edge is offered
    always @(negedge clk) begin
        cnt_reg <= cycle_busy ? cnt_reg + 10'h001 : 10'h000;
        transfer_ack_in <= !cycle_busy || cnt_reg >= low_cycles;
    end
endmodule // ack_device_model

// *** bench/ext_bus_ack_termination_tb_top.sv ***
// Bench for the acknowledge termination block
module ext_bus_ack_termination_tb_top import ack_term_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'h0, rst_n = 1'h0, cycle_start = 1'h0;
    logic       cycle_done, bus_error, cycle_busy, transfer_ack_in;
    cycle_cfg_t cycle_cfg = '0;
    logic [9:0] low_cycles = 10'h000;
    int         n_fail = 0, num_checks = 0, cyc = 0;
    ext_bus_ack_termination #(.TIMEOUT(16)) ext_bus_ack_termination_inst (.clk, .rst_n,
        .cycle_start, .cycle_cfg, .transfer_ack_in, .cycle_done, .bus_error, .cycle_busy);
    ack_device_model ack_device_model_inst (.clk, .cycle_busy, .low_cycles, .transfer_ack_in);
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) close_out(1'h1);
    task automatic chk(string nm, logic [1:0] s, x);
        num_checks++;
        n_fail += s !== x;
        if (s !== x) $display("MISMATCH %s exp %b seen %b", nm, x, s);
    endtask
    task automatic close_out(bit hung);
        n_fail += hung;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(logic [2:0] cs, logic e, logic [1:0] h, logic [9:0] lo, logic xd);
        int n = 0;
        low_cycles = lo;
        cycle_cfg = '{cs, e && cs == CS_EDGE_ONLY ? WSC_EDGE_MODE : 6'h02, h, e, 1'h1};
        cycle_start = 1'h1;
        @(negedge clk) cycle_start = 1'h0;
        chk("busy", {1'h0, cycle_busy}, 2'h1);
        while (cycle_done !== 1'h1 && bus_error !== 1'h1 && n++ < 64) @(negedge clk);
        chk("done_error", {cycle_done, bus_error}, {xd, !xd});
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        for (int h = 0; h < 4; h++) run(3'h1, 1'h0, h[1:0], 10'h000, 1'h1);
        run(3'h1, 1'h0, 2'h3, 10'h006, 1'h1);
        run(3'h1, 1'h0, 2'h0, 10'h064, 1'h0);
        run(3'h4, 1'h0, 2'h0, 10'h064, 1'h1);
        run(3'h5, 1'h1, 2'h0, 10'h003, 1'h1);
        run(3'h5, 1'h1, 2'h0, 10'h000, 1'h0);
        run(3'h2, 1'h1, 2'h0, 10'h000, 1'h1);
        close_out(1'h0);
    end
endmodule // ext_bus_ack_termination_tb_top
bind ext_bus_ack_termination ext_bus_ack_termination_properties #(.TIMEOUT(TIMEOUT)) props_inst
    (.clk, .rst_n, .cycle_start, .cycle_cfg, .transfer_ack_in,
     .cycle_done, .bus_error, .cycle_busy);
